// ==== oda_pkg.sv ====
// Shared constants and types for the on-chip debug access control block
package oda_pkg;

    // ==================================================================
    // Sizes
    localparam int ODA_NBP     = 8;  // Breakpoint entries (PC + data)
    localparam int ODA_NTC     = 2;  // Data trace channels
    localparam int ODA_DATA_BP = 6;  // Entry that owns the data register
    localparam int ODA_FRAME   = 39; // Serial frame: wr, index, data

    // ==================================================================
    // Register indices, byte address is index times four
    localparam logic [5:0] IDX_DC    = 6'h00;
    localparam logic [5:0] IDX_DS    = 6'h01;
    localparam logic [5:0] IDX_WT    = 6'h02;
    localparam logic [5:0] IDX_PID   = 6'h03;
    localparam logic [5:0] IDX_C2T   = 6'h04;
    localparam logic [5:0] IDX_T2C   = 6'h05;
    localparam logic [5:0] IDX_TCC   = 6'h06;
    localparam logic [5:0] IDX_BPC   = 6'h07;
    localparam logic [5:0] IDX_BPD   = 6'h08;
    localparam logic [5:0] IDX_DEBUG_INSTRUCTION_FEED = 6'h09;
    localparam logic [5:0] IDX_DPC   = 6'h0A;
    localparam logic [5:0] IDX_TSA0  = 6'h10; // 10,12 start; 11,13 end
    localparam logic [5:0] IDX_BPA0  = 6'h20; // 20..27

    // ==================================================================
    // Development control fields
    localparam int DC_OCD_EN  = 0;
    localparam int DC_DBG_REQ = 1;
    localparam int DC_PROTECT = 2;
    localparam int DC_MONITOR = 3;
    // Development status fields
    localparam int DS_ENTRY   = 0;
    localparam int DS_SWB     = 1;
    localparam int DS_STOP    = 2;
    // Trace control fields, channel enables in the low bits
    localparam int TC_PROG    = 4;
    localparam int TC_OWN     = 5;
    localparam logic [31:0] TC_EN_MASK = 32'h0000_0003;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;

    // ==================================================================
    // Debug sequencing states
    typedef enum logic [1:0] {
        ODA_RUN  = 2'b00,
        ODA_OCD  = 2'b01,
        ODA_WAIT = 2'b10,
        ODA_FEED = 2'b11
    } oda_state_t;

endpackage

// ==== oda_jtag_port.sv ====
// Serial test-port front end: sampled clock, frame shifter, read-back
`timescale 1ns/1ps
module oda_jtag_port
    import oda_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        jtag_tck,
    input  wire logic        jtag_tms,
    input  wire logic        jtag_tdi,
    input  wire logic [31:0] rd_data,
    output logic             jtag_tdo,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [5:0]       cmd_idx,
    output logic [31:0]      cmd_data
);
    logic [2:0]           s1_q;
    logic [2:0]           s2_q;
    logic                 tck_prev_q;
    logic                 tms_prev_q;
    logic [ODA_FRAME-1:0] sh_q;
    logic [5:0]           cnt_q;
    logic [31:0]          out_q;
    logic                 rise;
    logic                 frame_end;

    // ==================================================================
    // Two-flop synchronisers; stage two read
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q       <= 3'h0;
            s2_q       <= 3'h0;
            tck_prev_q <= 1'b0;
            tms_prev_q <= 1'b0;
        end
        else
        begin
            s1_q       <= {jtag_tdi, jtag_tms, jtag_tck};
            s2_q       <= s1_q;
            tck_prev_q <= s2_q[0];
            tms_prev_q <= s2_q[1];
        end
    end

    assign rise      = s2_q[0] & ~tck_prev_q & s2_q[1];
    assign frame_end = tms_prev_q & ~s2_q[1];

    // ==================================================================
    // Shift in, decode at frame end; bad lengths dropped
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sh_q     <= '0;
            cnt_q    <= 6'h00;
            cmd_wr   <= 1'b0;
            cmd_rd   <= 1'b0;
            cmd_idx  <= 6'h00;
            cmd_data <= 32'h0000_0000;
        end
        else
        begin
            cmd_wr <= 1'b0;
            cmd_rd <= 1'b0;
            if (rise)
            begin
                sh_q <= {s2_q[2], sh_q[ODA_FRAME-1:1]};
                if (cnt_q != 6'h3F)
                    cnt_q <= cnt_q + 6'h01;
            end
            else if (frame_end)
            begin
                cnt_q <= 6'h00;
                if (cnt_q == 6'(ODA_FRAME))
                begin
                    cmd_wr   <= sh_q[0];
                    cmd_rd   <= ~sh_q[0];
                    cmd_idx  <= sh_q[6:1];
                    cmd_data <= sh_q[38:7];
                end
            end
        end
    end

    // ==================================================================
    // Read data out LSB first during next frame
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_q    <= 32'h0000_0000;
            jtag_tdo <= 1'b0;
        end
        else if (cmd_rd)
            out_q <= rd_data;
        else if (rise)
        begin
            jtag_tdo <= out_q[0];
            out_q    <= {1'b0, out_q[31:1]};
        end
    end
endmodule // oda_jtag_port

// ==== oda_debug_ctrl.sv ====
// Debug access control: register file, write permissions, debug entry/exit
// Function
// [RQ1] Tool writes breakpoint opcode over halfword
// [RQ2] Tool saves aligned word before patching
// [RQ3] Breakpoint opcode: entry, entry/cause flags
// [RQ4] Tool adds two to return address
// [RQ5] Return leaves debug, reports, awaits word
// [RQ6] Resume address, fed word, normal fetch
// [RQ7] Sleeping core ignores normal requests
// [RQ8] Request in sleep wakes, tags, enters debug
// [RQ9] Entry from sleep sets stop status
// [RQ10] Return after sleep; tool may rewind
// [RQ11] All debug registers reachable from port
// [RQ12] Debug mode stops program/data trace
// [RQ13] Break/watch firing gated in debug
// [RQ14] Monitor moves to/from indexed registers
// [RQ15] Port free when disabled or halted
// [RQ16] Protected CPU writes PROCESS_ID_REGISTER, outbound only
// [RQ17] Running: shared registers writable, feed not
// [RQ18] Running port: trace enables, idle addresses
// [RQ19] Running port: enables; CPU needs mask
// [RQ20] Breakpoint address/data: enable, mask guard
// [RQ21] Tools keep permitted run-time writes
// [RQ22] Simultaneous writes: port wins
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module oda_debug_ctrl
    import oda_pkg::*;
#(
    parameter int NBP = ODA_NBP,
    parameter int NTC = ODA_NTC
)
(
    input  wire logic           sys_clk,
    input  wire logic           rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           jtag_tck,
    input  wire logic           jtag_tms,
    input  wire logic           jtag_tdi,
    output logic                jtag_tdo,
    input  wire logic           core_bkpt_exec,
    input  wire logic           core_retd,
    input  wire logic           core_sleeping,
    input  wire logic           core_priv,
    input  wire logic           core_monitor_debug,
    input  wire logic           debug_mask_bit,
    input  wire logic           feed_taken,
    output logic                ocd_mode,
    output logic                core_stall,
    output logic                feed_valid,
    output logic [31:0]         debug_instruction_feed,
    output logic                resume_load,
    output logic [31:0]         debug_program_counter,
    output logic                wake_req,
    output logic                tag_debug_exc,
    output logic                status_msg_valid,
    output logic [31:0]         status_msg_data,
    output logic                prog_trace_en,
    output logic [NTC-1:0]      data_trace_en,
    output logic                own_trace_en,
    output logic                bp_fire_ok,
    output logic                wp_fire_ok,
    output logic [NBP-1:0]      bp_enable
);
    oda_state_t  state_q;
    logic [31:0] dc_q, ds_q, wt_q, pid_q, c2t_q, t2c_q, tcc_q, bpc_q, bpd_q;
    logic [31:0] tsa_q [NTC];
    logic [31:0] tea_q [NTC];
    logic [31:0] bpa_q [NBP];
    logic        jwr, jrd, jwe, cwe, afire, jfull, clock;
    logic        ent_swb, ent_slp, ent_req, entry;
    logic [5:0]  jidx, cidx;
    logic [31:0] jdat, jrdata, tcc_j, bpc_j;

    // ==================================================================
    // Test-port front end
    oda_jtag_port u_port (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .jtag_tck (jtag_tck),
        .jtag_tms (jtag_tms),
        .jtag_tdi (jtag_tdi),
        .rd_data  (jrdata),
        .jtag_tdo (jtag_tdo),
        .cmd_wr   (jwr),
        .cmd_rd   (jrd),
        .cmd_idx  (jidx),
        .cmd_data (jdat)
    );

    // ==================================================================
    // Register read mux, shared by both masters
    function automatic logic [32:0] rd_reg(input logic [5:0] i);
        if (i == IDX_DC)         return {1'b1, dc_q};
        else if (i == IDX_DS)    return {1'b1, ds_q};
        else if (i == IDX_WT)    return {1'b1, wt_q};
        else if (i == IDX_PID)   return {1'b1, pid_q};
        else if (i == IDX_C2T)   return {1'b1, c2t_q};
        else if (i == IDX_T2C)   return {1'b1, t2c_q};
        else if (i == IDX_TCC)   return {1'b1, tcc_q};
        else if (i == IDX_BPC)   return {1'b1, bpc_q};
        else if (i == IDX_BPD)   return {1'b1, bpd_q};
        else if (i == IDX_DEBUG_INSTRUCTION_FEED) return {1'b1, debug_instruction_feed};
        else if (i == IDX_DPC)   return {1'b1, debug_program_counter};
        else if (i[5:2] == IDX_TSA0[5:2] && int'(i[1]) < NTC)
            return {1'b1, i[0] ? tea_q[i[1]] : tsa_q[i[1]]};
        else if (i[5:3] == IDX_BPA0[5:3] && int'(i[2:0]) < NBP)
            return {1'b1, bpa_q[i[2:0]]};
        else
            return {1'b0, 32'h0000_0000};
    endfunction

    assign jrdata = rd_reg(jidx)[31:0]; // [RQ11]

    // Port free while debug off or core not running (stall too)
    assign jfull = ~dc_q[DC_OCD_EN] | (state_q != ODA_RUN); // [RQ15]
    // Protect bit or user mode: two CPU-writable registers
    assign clock = dc_q[DC_PROTECT] | ~core_priv;

    // ==================================================================
    // Test-port write permission while the core runs
    function automatic logic jtag_ok(input logic [5:0] i);
        if (!rd_reg(i)[32] || i == IDX_DS)      return 1'b0;
        else if (jfull)                          return 1'b1; // [RQ15]
        else if (i == IDX_DEBUG_INSTRUCTION_FEED || i == IDX_DPC) return 1'b0; // [RQ17]
        else if (i[5:2] == IDX_TSA0[5:2])        return ~tcc_q[i[1]]; // [RQ18]
        else if (i[5:3] == IDX_BPA0[5:3])        return ~bpc_q[i[2:0]]; // [RQ20]
        else if (i == IDX_BPD)                   return ~bpc_q[ODA_DATA_BP]; // [RQ20]
        else                                     return 1'b1; // [RQ17]
    endfunction

    // CPU (monitor move instruction) write permission
    function automatic logic cpu_ok(input logic [5:0] i);
        if (!rd_reg(i)[32] || i == IDX_DS)      return 1'b0;
        else if (clock)                          return i == IDX_PID || i == IDX_C2T; // [RQ16]
        else if (i == IDX_DEBUG_INSTRUCTION_FEED || i == IDX_DPC) return 1'b0; // [RQ17]
        else if (i == IDX_BPC)                   return debug_mask_bit; // [RQ19]
        else if (i[5:3] == IDX_BPA0[5:3])        return debug_mask_bit | ~bpc_q[i[2:0]]; // [RQ20]
        else if (i == IDX_BPD)
            return debug_mask_bit | ~bpc_q[ODA_DATA_BP]; // [RQ20]
        else                                     return 1'b1; // [RQ17]
    endfunction

    assign cidx  = paddr[7:2];
    assign afire = psel & penable & pready & pwrite; // [RQ14]
    assign jwe   = jwr & jtag_ok(jidx);
    // A clashing CPU write is dropped silently
    assign cwe   = afire & cpu_ok(cidx) & ~(jwe && jidx == cidx); // [RQ22]

    // Running port flips only enable bits
    assign tcc_j = jfull ? jdat : (tcc_q & ~TC_EN_MASK) | (jdat & TC_EN_MASK); // [RQ18]
    assign bpc_j = jfull ? jdat : (bpc_q & ~32'(NBP'('1))) | (jdat & 32'(NBP'('1))); // [RQ19]

    // ==================================================================
    // APB slave: one wait state, answer registered
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~rd_reg(cidx)[32];
            if (psel & penable & ~pready & ~pwrite)
                prdata <= rd_reg(cidx)[31:0]; // [RQ14]
        end
    end

    // ==================================================================
    // Debug entry sources, only from normal run
    // Sleeping core reaches debug only through the wake path
    assign ent_swb = core_bkpt_exec; // [RQ3]
    assign ent_slp = dc_q[DC_DBG_REQ] & core_sleeping; // [RQ7] [RQ8]
    assign ent_req = dc_q[DC_DBG_REQ] & ~core_sleeping;
    assign entry   = state_q == ODA_RUN && dc_q[DC_OCD_EN] && !dc_q[DC_MONITOR]
                     && (ent_swb || ent_slp || ent_req);

    // ==================================================================
    // Development control; writes beat request self-clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            dc_q <= REG_RST;
        else if (jwe && jidx == IDX_DC)
            dc_q <= jdat;
        else if (cwe && cidx == IDX_DC)
            dc_q <= pwdata;
        else if (entry)
            dc_q[DC_DBG_REQ] <= 1'b0;
    end

    // ==================================================================
    // Plain shared registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wt_q  <= REG_RST;
            pid_q <= REG_RST;
            c2t_q <= REG_RST;
            t2c_q <= REG_RST;
            tcc_q <= REG_RST;
            bpc_q <= REG_RST;
            bpd_q <= REG_RST;
        end
        else
        begin
            if (jwe && jidx == IDX_WT)       wt_q  <= jdat;
            else if (cwe && cidx == IDX_WT)  wt_q  <= pwdata;
            if (jwe && jidx == IDX_PID)      pid_q <= jdat;
            else if (cwe && cidx == IDX_PID) pid_q <= pwdata;
            if (jwe && jidx == IDX_C2T)      c2t_q <= jdat;
            else if (cwe && cidx == IDX_C2T) c2t_q <= pwdata;
            if (jwe && jidx == IDX_T2C)      t2c_q <= jdat;
            else if (cwe && cidx == IDX_T2C) t2c_q <= pwdata;
            if (jwe && jidx == IDX_TCC)      tcc_q <= tcc_j;
            else if (cwe && cidx == IDX_TCC) tcc_q <= pwdata;
            if (jwe && jidx == IDX_BPC)      bpc_q <= bpc_j;
            else if (cwe && cidx == IDX_BPC) bpc_q <= pwdata;
            if (jwe && jidx == IDX_BPD)      bpd_q <= jdat;
            else if (cwe && cidx == IDX_BPD) bpd_q <= pwdata;
        end
    end

    // ==================================================================
    // Breakpoint and trace address registers
    for (genvar g = 0; g < NBP; g++)
    begin : g_bpa
        localparam logic [5:0] IX = 6'(int'(IDX_BPA0) + g);
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                bpa_q[g] <= REG_RST;
            else if (jwe && jidx == IX)
                bpa_q[g] <= jdat;
            else if (cwe && cidx == IX)
                bpa_q[g] <= pwdata;
        end
        if (g < NTC)
        begin : g_trc
            localparam logic [5:0] SX = 6'(int'(IDX_TSA0) + 2 * g);
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    tsa_q[g] <= REG_RST;
                    tea_q[g] <= REG_RST;
                end
                else
                begin
                    if (jwe && jidx == SX)                tsa_q[g] <= jdat;
                    else if (cwe && cidx == SX)           tsa_q[g] <= pwdata;
                    if (jwe && jidx == (SX | 6'h01))      tea_q[g] <= jdat;
                    else if (cwe && cidx == (SX | 6'h01)) tea_q[g] <= pwdata;
                end
            end
        end
    end

    // ==================================================================
    // Entry, return-from-debug and replay sequencing
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q          <= ODA_RUN;
            ds_q             <= REG_RST;
            ocd_mode         <= 1'b0;
            core_stall       <= 1'b0;
            resume_load      <= 1'b0;
            wake_req         <= 1'b0;
            tag_debug_exc    <= 1'b0;
            status_msg_valid <= 1'b0;
            status_msg_data  <= REG_RST;
        end
        else
        begin
            resume_load      <= 1'b0;
            wake_req         <= 1'b0;
            tag_debug_exc    <= 1'b0;
            status_msg_valid <= 1'b0;
            case (state_q)
                ODA_RUN:
                    if (entry)
                    begin
                        state_q          <= ODA_OCD;
                        ocd_mode         <= 1'b1;
                        ds_q             <= {29'h0, ent_slp, ent_swb, 1'b1}; // [RQ3] [RQ9]
                        status_msg_valid <= 1'b1;
                        status_msg_data  <= {29'h0, ent_slp, ent_swb, 1'b1};
                        wake_req         <= ent_slp; // [RQ8]
                        tag_debug_exc    <= ent_slp; // [RQ8] [RQ10]
                    end
                ODA_OCD:
                    if (core_retd)
                    begin
                        state_q          <= ODA_WAIT; // [RQ5]
                        ocd_mode         <= 1'b0;
                        core_stall       <= 1'b1;
                        ds_q             <= REG_RST;
                        status_msg_valid <= 1'b1;
                        status_msg_data  <= REG_RST;
                    end
                ODA_WAIT:
                    if (jwe && jidx == IDX_DEBUG_INSTRUCTION_FEED)
                        state_q <= ODA_FEED; // [RQ6]
                ODA_FEED:
                    if (feed_taken)
                    begin
                        state_q     <= ODA_RUN; // [RQ6]
                        core_stall  <= 1'b0;
                        resume_load <= 1'b1;
                    end
                default:
                    state_q <= ODA_RUN;
            endcase
        end
    end

    // ==================================================================
    // Instruction feed and resume counter, test port only
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            feed_valid             <= 1'b0;
            debug_instruction_feed <= REG_RST;
            debug_program_counter  <= REG_RST;
        end
        else
        begin
            if (jwe && jidx == IDX_DPC)
                debug_program_counter <= jdat; // [RQ6]
            if (jwe && jidx == IDX_DEBUG_INSTRUCTION_FEED)
            begin
                debug_instruction_feed <= jdat;
                feed_valid             <= state_q != ODA_RUN; // [RQ5] [RQ6]
            end
            else if (feed_taken)
                feed_valid <= 1'b0;
        end
    end

    // ==================================================================
    // Feature gating in OCD mode; program/data trace, and breakpoints when masked, also in monitor debug
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prog_trace_en <= 1'b0;
            data_trace_en <= '0;
            own_trace_en  <= 1'b0;
            bp_fire_ok    <= 1'b0;
            wp_fire_ok    <= 1'b0;
            bp_enable     <= '0;
        end
        else
        begin
            prog_trace_en <= tcc_q[TC_PROG] & ~(ocd_mode | core_monitor_debug); // [RQ12]
            data_trace_en <= tcc_q[NTC-1:0] & {NTC{~(ocd_mode | core_monitor_debug)}}; // [RQ12]
            own_trace_en  <= tcc_q[TC_OWN]; // [RQ12]
            bp_fire_ok    <= ~ocd_mode & (~core_monitor_debug | ~debug_mask_bit); // [RQ13]
            wp_fire_ok    <= ~ocd_mode; // [RQ13]
            bp_enable     <= bpc_q[NBP-1:0];
        end
    end
endmodule // oda_debug_ctrl

// ==== oda_ctrl_assertions.sv ====
// Port-level checks for the debug access control block
`timescale 1ns/1ps
module oda_ctrl_assertions
    import oda_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_retd,
    input wire logic feed_taken,
    input wire logic feed_valid,
    input wire logic ocd_mode,
    input wire logic core_stall,
    input wire logic resume_load,
    input wire logic status_msg_valid,
    input wire logic prog_trace_en,
    input wire logic wp_fire_ok
);
    // ====================
    // One clock domain
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    bus_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    entry_msg_a: assert property ($rose(ocd_mode) |-> ##[0:1] status_msg_valid)
        else $error("no message on entry");
    retd_exit_a: assert property (ocd_mode && core_retd |=> !ocd_mode && core_stall)
        else $error("return did not stall");
    exit_msg_a: assert property (ocd_mode && core_retd |-> ##[1:2] status_msg_valid)
        else $error("no message on exit");
    stall_hold_a: assert property (core_stall && !feed_taken |=> core_stall)
        else $error("stall dropped early");
    resume_go_a: assert property (core_stall && feed_valid && feed_taken |=> resume_load)
        else $error("no resume after feed");
    trace_off_a: assert property (ocd_mode |=> !prog_trace_en)
        else $error("trace on in debug");
    watch_off_a: assert property (ocd_mode |=> !wp_fire_ok)
        else $error("watch on in debug");
    cover property ($rose(ocd_mode));
    cover property (resume_load);
    cover property (pready && pslverr);
endmodule // oda_ctrl_assertions

bind oda_debug_ctrl oda_ctrl_assertions i_chk (.*);

// ==== oda_jtag_tool.sv ====
// Behavioural debug tool on the serial test port
`timescale 1ns/1ps
module oda_jtag_tool
(
    output logic     jtag_tck,
    output logic     jtag_tms,
    output logic     jtag_tdi,
    input wire logic jtag_tdo
);
    localparam int HALF = 400; // 800 ns link clock
    // ====================
    // Idle: clock still, frame marker low
    initial
    begin
        jtag_tck = 1'b0;
        jtag_tms = 1'b0;
        jtag_tdi = 1'b0;
    end
    // One frame LSB first; tdo read before rises 2 to 33
    task automatic frame(input logic [38:0] f, output logic [31:0] q);
        jtag_tms = 1'b1;
        for (int i = 0; i < 39; i++)
        begin
            jtag_tdi = f[i];
            #HALF;
            if (i > 0 && i < 33)
                q[i-1] = jtag_tdo;
            jtag_tck = 1'b1;
            #HALF jtag_tck = 1'b0;
        end
        jtag_tms = 1'b0;
        jtag_tdi = ~jtag_tdi; // Released line keeps no stale bit
        #(HALF * 3); // Gap lets the command land
    endtask
endmodule // oda_jtag_tool

// ==== tb.sv ====
// Self-checking bench for the debug access control block
`timescale 1ns/1ps
module tb;
    import oda_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, bp_enable;
    logic [31:0] pwdata, prdata, q, p, debug_instruction_feed, debug_program_counter;
    logic [31:0] status_msg_data, seed = 32'h0000_d4ff;
    logic jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, core_bkpt_exec, core_retd, core_sleeping;
    logic core_priv, core_monitor_debug, debug_mask_bit, feed_taken, ocd_mode, core_stall;
    logic feed_valid, resume_load, wake_req, tag_debug_exc, status_msg_valid, woke = 1'b0;
    logic prog_trace_en, own_trace_en, bp_fire_ok, wp_fire_ok;
    logic [1:0] data_trace_en;
    int mismatches = 0, comparisons = 0, cyc = 0;
    localparam logic [31:0] SAVED = 32'hC0AC_F807; // Whole word kept by tool
    oda_debug_ctrl i_dut (.*);
    oda_jtag_tool i_tool (.jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo);
    // ====================
    // Clock, hang guard and wake monitor
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        woke <= woke | (wake_req & tag_debug_exc);
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Port may only move channel enables while running
    function automatic logic [31:0] tc_exp(input logic [31:0] o, n);
        return {o[31:2], n[1:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic jw(input logic [5:0] i, input logic [31:0] d);
        i_tool.frame({d, i, 1'b1}, p);
    endtask
    task automatic print_verdict();
        $display("TB: mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, core_bkpt_exec, core_retd} = '0;
        {core_sleeping, core_monitor_debug, debug_mask_bit, feed_taken} = '0;
        {core_priv, rst} = 2'b11;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, 8'hFC, 0); chk({e, q[30:0]}, 32'h8000_0000);
        seed = xs(seed);
        apb(1, 8'h0C, seed); apb(0, 8'h0C, 0); chk(q, seed);
        core_priv <= 1'b0;
        apb(1, 8'h08, seed); apb(1, 8'h10, ~seed); apb(1, 8'h28, seed);
        apb(0, 8'h08, 0); chk(q, 0);
        apb(0, 8'h10, 0); chk(q, ~seed);
        chk(debug_program_counter, 0);
        core_priv <= 1'b1;
        i_tool.frame({32'h0, IDX_PID, 1'b0}, q); i_tool.frame('0, q); chk(q, seed);
        jw(IDX_DC, 1); apb(0, 8'h00, 0); chk(q, 1);
        apb(1, 8'h18, 32'h0000_0033); repeat (2) @(posedge sys_clk);
        chk({prog_trace_en, data_trace_en}, 3'b111);
        seed = xs(seed);
        jw(IDX_TSA0, seed); apb(0, 8'h40, 0); chk(q, 0);
        jw(IDX_TCC, 0); apb(0, 8'h18, 0); chk(q, tc_exp(32'h33, 0));
        jw(IDX_TSA0, seed); apb(0, 8'h40, 0); chk(q, seed);
        apb(1, 8'h1C, 1); chk(bp_enable, 0);
        {debug_mask_bit, core_monitor_debug} <= 2'b11;
        apb(1, 8'h1C, 1); repeat (2) @(posedge sys_clk);
        chk(bp_enable, 1); chk(bp_fire_ok, 0);
        {debug_mask_bit, core_monitor_debug} <= 2'b00;
        jw(IDX_BPA0, seed); apb(0, 8'h80, 0); chk(q, 0);
        jw(IDX_BPA0 + 6'h01, seed); apb(0, 8'h84, 0); chk(q, seed);
        @(posedge sys_clk) core_bkpt_exec <= 1'b1; // Patched opcode runs
        @(posedge sys_clk) core_bkpt_exec <= 1'b0;
        apb(0, 8'h04, 0); chk({q[2:0], ocd_mode}, 4'b0111);
        chk({prog_trace_en, own_trace_en, wp_fire_ok}, 3'b010);
        @(posedge sys_clk) core_retd <= 1'b1;
        @(posedge sys_clk) core_retd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({ocd_mode, core_stall}, 2'b01);
        jw(IDX_DPC, 32'h16); jw(IDX_DEBUG_INSTRUCTION_FEED, SAVED);
        chk({debug_instruction_feed ^ SAVED, feed_valid}, 32'h1);
        chk(debug_program_counter, 32'h16);
        @(posedge sys_clk) feed_taken <= 1'b1;
        @(posedge sys_clk) feed_taken <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(core_stall, 0);
        core_sleeping <= 1'b1;
        jw(IDX_DC, 3); apb(0, 8'h04, 0);
        chk({status_msg_data[2:0], q[2:0], ocd_mode, woke}, 8'hB7);
        print_verdict();
    end
endmodule // tb
